// [design/spi_target_unit.sv]
// SPI target unit: semaphore, bit engine and RAM access engine
`timescale 1ns/1ps

// Function
// - Fill with overrun char once TX buffer exhausted
// - Done event only after RAM accesses finish
// - CPU takes semaphore, waits for granted event
// - Give while CPU not owner does nothing
// - Done-to-CPU shortcut hands semaphore to CPU
// - RX full event when limit bytes received
// - Drop bytes past RX limit, set excess flag
// - Fill extra reads, set TX underrun flag
// - Report stored RX and loaded TX byte counts, capped at limits
// - CPU owns semaphore after enable, no event
// - Take while CPU owns grants at once
// - Select low with CPU owner ignores transaction
// - Ignored stays ignored until select rises
// - Same-instant requests go to the CPU
// - Granted: store received, send TX buffer bytes
// - Select high ends grant, release, done event
// - CPU take during grant served after release
// - Shortcut serves only one pending take
// - Disconnected pin leaves signal unattached
// - Pins follow GPIO settings when disabled
// - Output line high impedance when not selected
// - All four clock modes via polarity, phase
module spi_target_unit
  import spi_target_pkg::*;
(
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst_n,
  input  wire logic              i_enable,
  input  wire logic              i_clock_polarity_bit,
  input  wire logic              i_clock_phase_bit,
  input  wire logic              i_short_end_acquire,
  input  wire logic              i_take_task,
  input  wire logic              i_give_task,
  input  wire logic [1:0]        i_status_clear,
  input  wire logic [ADDR_W-1:0] i_rx_buffer_pointer,
  input  wire logic [ADDR_W-1:0] i_tx_buffer_pointer,
  input  wire logic [CNT_W-1:0]  i_rx_byte_limit,
  input  wire logic [CNT_W-1:0]  i_tx_byte_limit,
  input  wire logic [BYTE_W-1:0] i_overrun_fill_char,
  input  wire logic [BYTE_W-1:0] i_ignored_fill_char,
  input  wire logic              i_select_pin_choice,
  input  wire logic              i_clock_pin_choice,
  input  wire logic              i_data_in_pin_choice,
  input  wire logic              i_data_out_pin_choice,
  input  wire logic              i_pin_select_n,
  input  wire logic              i_pin_clock,
  input  wire logic              i_pin_data_in,
  input  wire logic              i_gpio_data_out,
  input  wire logic              i_gpio_data_out_oe_n,
  output logic                   o_pin_data_out,
  output logic                   o_pin_data_out_oe_n,
  output logic                   o_mem_req,
  output logic                   o_mem_we,
  output logic      [ADDR_W-1:0] o_mem_addr,
  output logic      [BYTE_W-1:0] o_mem_wdata,
  input  wire logic              i_mem_ack,
  input  wire logic [BYTE_W-1:0] i_mem_rdata,
  output logic                   o_done_event,
  output logic                   o_rx_buffer_full_event,
  output logic                   o_sem_granted_event,
  output logic      [1:0]        o_sem_owner,
  output logic                   o_rx_excess_flag,
  output logic                   o_tx_underrun_flag,
  output logic      [CNT_W-1:0]  o_rx_bytes_done,
  output logic      [CNT_W-1:0]  o_tx_bytes_done
);

  typedef struct packed {
    sem_t              sem;
    txn_t              txn;
    logic              take_pend;
    logic              csn_q;
    logic              sck_q;
    logic [2:0]        bit_cnt;
    logic [BYTE_W-1:0] rx_sh;
    logic [BYTE_W-1:0] tx_sh;
    logic              miso;
    logic              miso_oe_n;
    logic [CNT_W-1:0]  rx_cnt;
    logic [CNT_W-1:0]  tx_cnt;
    logic [CNT_W-1:0]  tx_idx;
    logic [BYTE_W-1:0] tx_buf;
    logic              rd_pend;
    logic              rd_stale;
    logic              wr_pend;
    logic [ADDR_W-1:0] wr_addr;
    logic [BYTE_W-1:0] wr_data;
    logic              mem_req;
    logic              mem_we;
    logic [ADDR_W-1:0] mem_addr;
    logic [BYTE_W-1:0] mem_wdata;
    logic              done_evt;
    logic              full_evt;
    logic              grant_evt;
    logic              excess;
    logic              underrun;
    logic [CNT_W-1:0]  rx_done;
    logic [CNT_W-1:0]  tx_done;
  } unit_state_t;

  unit_state_t st;
  unit_state_t next_st;

  // ==========================================================================
  // Pin attachment and synchronisers
  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] pins_s;
  logic              csn_s;
  logic              sck_s;
  logic              mosi_s;
  logic              csn_fall;
  logic              csn_rise;
  logic              leading;
  logic              trailing;
  logic              sample_edge;
  logic              shift_edge;
  logic              load_byte;
  logic              active;

  // Disconnected inputs read as idle levels
  always_comb
  begin
    pins_raw[LANE_CSN]  = i_select_pin_choice ? i_pin_select_n : 1'b1;
    pins_raw[LANE_SCK]  = i_clock_pin_choice ? i_pin_clock : i_clock_polarity_bit;
    pins_raw[LANE_MOSI] = i_data_in_pin_choice & i_pin_data_in;
  end

  pin_sync #(
    .WIDTH (SYNC_W)
  ) u_pin_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_async   (pins_raw),
    .i_rst_val ({SYNC_W{1'b1}}),
    .o_sync    (pins_s)
  );

  // Edges come from the synchronised copy against our own last sample
  always_comb
  begin
    csn_s       = pins_s[LANE_CSN] | ~i_enable;
    sck_s       = pins_s[LANE_SCK];
    mosi_s      = pins_s[LANE_MOSI];
    csn_fall    = st.csn_q & ~csn_s;
    csn_rise    = ~st.csn_q & csn_s;
    leading     = (sck_s != st.sck_q) & (sck_s != i_clock_polarity_bit);
    trailing    = (sck_s != st.sck_q) & (sck_s == i_clock_polarity_bit);
    sample_edge = i_clock_phase_bit ? trailing : leading;
    shift_edge  = i_clock_phase_bit ? leading : trailing;
    active      = ~csn_s & ((st.txn == TXN_GRANTED) | (st.txn == TXN_IGNORED));
  end

  // ==========================================================================
  // Next state: semaphore, bit engine, RAM access engine
  always_comb
  begin
    next_st           = st;
    load_byte         = 1'b0;
    next_st.done_evt  = 1'b0;
    next_st.full_evt  = 1'b0;
    next_st.grant_evt = 1'b0;
    next_st.csn_q     = csn_s;
    next_st.sck_q     = sck_s;
    // Clear first so that a flag set in the same cycle survives
    if (i_status_clear[CLR_OVERFLOW])
    begin
      next_st.excess = 1'b0;
    end
    if (i_status_clear[CLR_UNDERRUN])
    begin
      next_st.underrun = 1'b0;
    end

    // CPU tasks act before the unit looks at the owner, so the CPU wins a tie
    if (i_take_task)
    begin
      unique case (st.sem)
        SEM_FREE, SEM_CPU:
        begin
          next_st.sem       = SEM_CPU;
          next_st.grant_evt = 1'b1;
        end
        SEM_UNIT:
        begin
          next_st.take_pend = 1'b1;
        end
        default:
        begin
          next_st.sem = SEM_CPU;
        end
      endcase
    end
    else if (i_give_task && st.sem == SEM_CPU)
    begin
      next_st.sem      = SEM_FREE;
      next_st.tx_idx   = CNT_ZERO;
      next_st.rd_pend  = (i_tx_byte_limit != CNT_ZERO);
      next_st.rd_stale = st.mem_req & ~st.mem_we;
    end

    // Select edges drive the transaction state
    if (csn_fall && st.txn == TXN_IDLE)
    begin
      next_st.bit_cnt = BIT_FIRST;
      next_st.rx_cnt  = CNT_ZERO;
      next_st.tx_cnt  = CNT_ZERO;
      if (next_st.sem == SEM_FREE)
      begin
        next_st.sem = SEM_UNIT;
        next_st.txn = TXN_GRANTED;
      end
      else
      begin
        next_st.txn = TXN_IGNORED;
      end
      load_byte = ~i_clock_phase_bit;
    end
    else if (csn_rise)
    begin
      if (st.txn == TXN_GRANTED)
      begin
        next_st.txn = TXN_END_WAIT;
      end
      else if (st.txn == TXN_IGNORED)
      begin
        next_st.txn = TXN_IDLE;
      end
    end

    // Bit engine, shared by granted and ignored transactions
    if (active && sample_edge)
    begin
      next_st.rx_sh   = {st.rx_sh[BYTE_W-2:0], mosi_s};
      next_st.bit_cnt = st.bit_cnt + 3'h1;
      if (st.bit_cnt == BIT_LAST && st.txn == TXN_GRANTED)
      begin
        if (st.rx_cnt < i_rx_byte_limit)
        begin
          next_st.wr_pend = 1'b1;
          next_st.wr_addr = i_rx_buffer_pointer + {ADDR_PAD, st.rx_cnt};
          next_st.wr_data = {st.rx_sh[BYTE_W-2:0], mosi_s};
          next_st.rx_cnt  = st.rx_cnt + CNT_ONE;
          next_st.full_evt = (st.rx_cnt + CNT_ONE == i_rx_byte_limit);
        end
        else
        begin
          next_st.excess = 1'b1;
        end
      end
    end
    if (active && shift_edge)
    begin
      if (st.bit_cnt == BIT_FIRST)
      begin
        load_byte = 1'b1;
      end
      else
      begin
        next_st.miso  = st.tx_sh[BYTE_W-1];
        next_st.tx_sh = {st.tx_sh[BYTE_W-2:0], 1'b0};
      end
    end

    // Pick the next outgoing byte
    if (load_byte)
    begin
      if (next_st.txn == TXN_IGNORED)
      begin
        next_st.miso  = i_ignored_fill_char[BYTE_W-1];
        next_st.tx_sh = {i_ignored_fill_char[BYTE_W-2:0], 1'b0};
      end
      // Count from next_st: a select fall in this cycle has just cleared the stale count
      else if (next_st.tx_cnt < i_tx_byte_limit)
      begin
        next_st.miso    = st.tx_buf[BYTE_W-1];
        next_st.tx_sh   = {st.tx_buf[BYTE_W-2:0], 1'b0};
        next_st.tx_cnt  = next_st.tx_cnt + CNT_ONE;
        next_st.tx_idx  = st.tx_idx + CNT_ONE;
        next_st.rd_pend = (st.tx_idx + CNT_ONE < i_tx_byte_limit);
      end
      else
      begin
        next_st.miso     = i_overrun_fill_char[BYTE_W-1];
        next_st.tx_sh    = {i_overrun_fill_char[BYTE_W-2:0], 1'b0};
        next_st.underrun = 1'b1;
      end
    end

    // RAM access engine: one access at a time, writes first
    if (st.mem_req)
    begin
      if (i_mem_ack)
      begin
        next_st.mem_req = 1'b0;
        if (!st.mem_we)
        begin
          next_st.rd_stale = 1'b0;
          if (!st.rd_stale)
          begin
            next_st.tx_buf = i_mem_rdata;
          end
        end
      end
    end
    else if (st.wr_pend)
    begin
      next_st.wr_pend   = 1'b0;
      next_st.mem_req   = 1'b1;
      next_st.mem_we    = 1'b1;
      next_st.mem_addr  = st.wr_addr;
      next_st.mem_wdata = st.wr_data;
    end
    else if (st.rd_pend)
    begin
      next_st.rd_pend  = 1'b0;
      next_st.mem_req  = 1'b1;
      next_st.mem_we   = 1'b0;
      next_st.mem_addr = i_tx_buffer_pointer + {ADDR_PAD, st.tx_idx};
    end

    // Completion waits until every RAM access of the transaction is over
    if (st.txn == TXN_END_WAIT && !st.wr_pend && !st.rd_pend && !st.mem_req)
    begin
      next_st.txn      = TXN_IDLE;
      next_st.done_evt = 1'b1;
      next_st.rx_done  = st.rx_cnt;
      next_st.tx_done  = st.tx_cnt;
      if (st.take_pend || i_take_task || i_short_end_acquire)
      begin
        next_st.sem       = SEM_CPU;
        next_st.grant_evt = 1'b1;
        next_st.take_pend = 1'b0;
      end
      else
      begin
        next_st.sem     = SEM_FREE;
        next_st.tx_idx  = CNT_ZERO;
        next_st.rd_pend = (i_tx_byte_limit != CNT_ZERO);
      end
    end

    // Output pin: driven only while selected, GPIO owns it when disabled
    if (i_enable)
    begin
      next_st.miso_oe_n = ~(i_data_out_pin_choice & ~csn_s);
    end
    else
    begin
      next_st.miso_oe_n = i_gpio_data_out_oe_n;
    end

    // Disabled unit: CPU owns the semaphore, no pending take, no granted event
    if (!i_enable)
    begin
      next_st.sem       = SEM_CPU;
      next_st.txn       = TXN_IDLE;
      next_st.take_pend = 1'b0;
      next_st.grant_evt = 1'b0;
      next_st.miso      = i_gpio_data_out;
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st           <= '0;
      st.sem       <= SEM_CPU;
      st.txn       <= TXN_IDLE;
      st.csn_q     <= 1'b1;
      st.miso_oe_n <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign o_pin_data_out         = st.miso;
  assign o_pin_data_out_oe_n    = st.miso_oe_n;
  assign o_mem_req              = st.mem_req;
  assign o_mem_we               = st.mem_we;
  assign o_mem_addr             = st.mem_addr;
  assign o_mem_wdata            = st.mem_wdata;
  assign o_done_event           = st.done_evt;
  assign o_rx_buffer_full_event = st.full_evt;
  assign o_sem_granted_event    = st.grant_evt;
  assign o_sem_owner            = st.sem;
  assign o_rx_excess_flag       = st.excess;
  assign o_tx_underrun_flag     = st.underrun;
  assign o_rx_bytes_done        = st.rx_done;
  assign o_tx_bytes_done        = st.tx_done;

  // ==========================================================================
  // Assertions
  a_give_noop: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_enable && st.txn == TXN_GRANTED && i_give_task) |=> (st.sem == SEM_UNIT))
    else $error("give while unit owns semaphore changed owner");

  a_take_immediate: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_enable && st.sem == SEM_CPU && i_take_task) |=> o_sem_granted_event)
    else $error("take while CPU owns gave no granted event");

  a_enable_silent: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    $rose(i_enable) |=> (o_sem_owner == SEM_CPU) && !o_sem_granted_event)
    else $error("enable did not hand semaphore quietly to CPU");

  a_ignored_holds: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (st.txn == TXN_IGNORED && i_enable) |=> (st.txn == TXN_IGNORED) || (st.txn == TXN_IDLE))
    else $error("ignored transaction became granted");

  a_race_cpu: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_enable && csn_fall && i_take_task && st.sem == SEM_FREE && st.txn == TXN_IDLE)
      |=> (st.sem == SEM_CPU) && (st.txn == TXN_IGNORED))
    else $error("simultaneous request not awarded to CPU");

  a_done_after_ram: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_done_event |-> !st.wr_pend && !o_mem_req && $past(st.txn) == TXN_END_WAIT)
    else $error("done event raised with RAM access outstanding");

  a_done_handover: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_done_event |-> (o_sem_granted_event == (o_sem_owner == SEM_CPU)))
    else $error("semaphore handover and granted event disagree");

  a_out_hiz: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_enable && csn_s) [*2] |-> o_pin_data_out_oe_n)
    else $error("output line driven while not selected");

  a_excess_flag: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (active && sample_edge && st.bit_cnt == BIT_LAST && st.txn == TXN_GRANTED
      && st.rx_cnt >= i_rx_byte_limit) |=> o_rx_excess_flag && !st.wr_pend)
    else $error("byte past receive limit not flagged or not dropped");

  a_underrun_flag: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (load_byte && next_st.txn == TXN_GRANTED && (csn_fall ? CNT_ZERO : st.tx_cnt) >= i_tx_byte_limit)
      |=> o_tx_underrun_flag && (o_pin_data_out == i_overrun_fill_char[BYTE_W-1]))
    else $error("over-read did not send fill or set flag");

  c_granted: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) o_done_event);
  c_ignored: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    st.txn == TXN_IGNORED ##1 st.txn == TXN_IDLE);
  c_full: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) o_rx_buffer_full_event);
  c_shortcut: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_done_event && o_sem_granted_event);

endmodule : spi_target_unit

// [design/spi_target_pkg.sv]
// Shared constants and types for the SPI target unit with RAM access
package spi_target_pkg;

  // ==========================================================================
  // Widths
  localparam int BYTE_W = 8;
  localparam int CNT_W  = 16;
  localparam int ADDR_W = 32;
  localparam int SYNC_W = 3;

  // ==========================================================================
  // Bit positions and fixed values
  localparam logic [2:0]        BIT_FIRST = 3'h0;
  localparam logic [2:0]        BIT_LAST  = 3'h7;
  localparam logic [CNT_W-1:0]  CNT_ZERO  = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_ONE   = 16'h0001;
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 32'h0000_0000;
  localparam logic [ADDR_W-CNT_W-1:0] ADDR_PAD = 16'h0000;

  // Sync lane positions
  localparam int LANE_CSN  = 0;
  localparam int LANE_SCK  = 1;
  localparam int LANE_MOSI = 2;

  // Status clear strobe positions
  localparam int CLR_OVERFLOW = 0;
  localparam int CLR_UNDERRUN = 1;

  // ==========================================================================
  // Semaphore owner
  typedef enum logic [1:0] {
    SEM_FREE = 2'b00,
    SEM_CPU  = 2'b01,
    SEM_UNIT = 2'b10
  } sem_t;

  // Transaction state
  typedef enum logic [1:0] {
    TXN_IDLE     = 2'b00,
    TXN_GRANTED  = 2'b01,
    TXN_IGNORED  = 2'b10,
    TXN_END_WAIT = 2'b11
  } txn_t;

endpackage : spi_target_pkg

// [design/pin_sync.sv]
// Two-flop synchroniser for pins arriving from outside the clock domain
`timescale 1ns/1ps
module pin_sync
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_async,
  input  wire logic [WIDTH-1:0] i_rst_val,
  output logic      [WIDTH-1:0] o_sync
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  // ==========================================================================
  // Stage one is read by stage two only
  always_comb
  begin
    next_st    = st;
    next_st.s1 = i_async;
    next_st.s2 = st.s1;
  end

  // Reset value is a constant idle level, not the pin itself
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st <= '1;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign o_sync = st.s2 | (i_rst_val & ~i_rst_val);

endmodule : pin_sync

// [tb/spi_controller_model.sv]
// Behavioural SPI controller that drives select, clock and data into the target
`timescale 1ns/1ps
module spi_controller_model
(
  output logic            o_select_n,
  output logic            o_clock,
  output logic            o_data,
  input  wire logic       i_data,
  input  wire logic       i_clock_polarity_bit,
  input  wire logic       i_clock_phase_bit
);
  // ==========================================================================
  // Idle state: clock stands at its polarity outside frames
  initial
  begin
    o_select_n = 1'b1;
    o_clock    = 1'b0;
    o_data     = 1'b0;
  end

  task idle();
    o_clock = i_clock_polarity_bit;
  endtask : idle

  // Margin after select so the target's synchroniser sees the fall
  task begin_frame();
    o_select_n = 1'b0;
    #48;
  endtask : begin_frame

  // One byte, MSB first; half period 16 ns
  task xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      if (!i_clock_phase_bit) o_data = tx[i];
      #16 o_clock = ~i_clock_polarity_bit;
      if (i_clock_phase_bit) o_data = tx[i];
      else rx[i] = i_data;
      #16 o_clock = i_clock_polarity_bit;
      if (i_clock_phase_bit) rx[i] = i_data;
    end
  endtask : xfer

  // Released data line shows the inverse, never a stale value
  task end_frame();
    #16 o_select_n = 1'b1;
    o_data = ~o_data;
    #64;
  endtask : end_frame
endmodule : spi_controller_model

// [tb/spi_target_unit_tb_top.sv]
// Self-checking bench for the SPI target unit
`timescale 1ns/1ps
module spi_target_unit_tb_top;
  import spi_target_pkg::*;
  logic i_clk_sys, i_rst_n, i_enable, i_clock_polarity_bit, i_clock_phase_bit, i_short_end_acquire;
  logic i_take_task, i_give_task, i_pin_select_n, i_pin_clock, i_pin_data_in;
  logic i_gpio_data_out, i_gpio_data_out_oe_n, i_mem_ack = 1'b0, o_pin_data_out, o_pin_data_out_oe_n;
  logic o_mem_req, o_mem_we, o_done_event, o_rx_buffer_full_event, o_sem_granted_event;
  logic o_rx_excess_flag, o_tx_underrun_flag;
  logic [1:0] i_status_clear, o_sem_owner;
  logic [ADDR_W-1:0] i_rx_buffer_pointer, i_tx_buffer_pointer, o_mem_addr;
  logic [CNT_W-1:0] i_rx_byte_limit, i_tx_byte_limit, o_rx_bytes_done, o_tx_bytes_done;
  logic [BYTE_W-1:0] i_overrun_fill_char, i_ignored_fill_char, o_mem_wdata, i_mem_rdata = 8'h00, rx;
  logic [BYTE_W-1:0] ram [256];
  int bad_count, samples_checked, n_done, n_full, n_grant, n_write;

  // ==========================================================================
  // Design and far side; pin choices stay connected, never changed while enabled
  spi_target_unit u_dut (.i_clk_sys, .i_rst_n, .i_enable, .i_clock_polarity_bit, .i_clock_phase_bit,
    .i_short_end_acquire, .i_take_task, .i_give_task, .i_status_clear, .i_rx_buffer_pointer,
    .i_tx_buffer_pointer, .i_rx_byte_limit, .i_tx_byte_limit, .i_overrun_fill_char, .i_ignored_fill_char,
    .i_select_pin_choice(1'b1), .i_clock_pin_choice(1'b1), .i_data_in_pin_choice(1'b1),
    .i_data_out_pin_choice(1'b1), .i_pin_select_n, .i_pin_clock, .i_pin_data_in, .i_gpio_data_out,
    .i_gpio_data_out_oe_n, .o_pin_data_out, .o_pin_data_out_oe_n, .o_mem_req, .o_mem_we, .o_mem_addr,
    .o_mem_wdata, .i_mem_ack, .i_mem_rdata, .o_done_event, .o_rx_buffer_full_event, .o_sem_granted_event,
    .o_sem_owner, .o_rx_excess_flag, .o_tx_underrun_flag, .o_rx_bytes_done, .o_tx_bytes_done);
  spi_controller_model u_ctrl (.o_select_n(i_pin_select_n), .o_clock(i_pin_clock), .o_data(i_pin_data_in),
    .i_data(o_pin_data_out), .i_clock_polarity_bit, .i_clock_phase_bit);

  initial
  begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end

  // ==========================================================================
  // RAM answers one cycle after a request; read data is scrambled between acks
  always @(posedge i_clk_sys)
  begin
    #1;
    if (i_mem_ack)
    begin
      i_mem_ack = 1'b0;
      i_mem_rdata = ~i_mem_rdata;
    end
    else if (o_mem_req === 1'b1)
    begin
      i_mem_ack = 1'b1;
      if (o_mem_we) ram[o_mem_addr[7:0]] = o_mem_wdata;
      if (o_mem_we) n_write++;
      i_mem_rdata = ram[o_mem_addr[7:0]];
    end
  end

  // Event pulses last one cycle, so count them at every edge
  always @(posedge i_clk_sys)
  begin
    if (o_done_event === 1'b1) n_done++;
    if (o_rx_buffer_full_event === 1'b1) n_full++;
    if (o_sem_granted_event === 1'b1) n_grant++;
  end

  // ==========================================================================
  // Helpers
  task cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask : cyc

  // One-cycle pulse on {take, give, clear}
  task strobe(input logic [3:0] sel);
    cyc(1);
    {i_take_task, i_give_task, i_status_clear} = sel;
    cyc(1);
    {i_take_task, i_give_task, i_status_clear} = 4'h0;
  endtask : strobe

  task check(input string name, input logic [CNT_W-1:0] exp, input logic [CNT_W-1:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  initial
  begin
    #100000;
    bad_count++;
    end_of_test();
  end

  // ==========================================================================
  // Main sequence; every setting is written before enabling
  initial
  begin
    {i_rst_n, i_enable, i_clock_polarity_bit, i_clock_phase_bit, i_short_end_acquire} = 5'h00;
    {i_take_task, i_give_task, i_status_clear} = 4'h0;
    {i_rx_buffer_pointer, i_tx_buffer_pointer} = {32'h0000_0080, 32'h0000_0040};
    {i_rx_byte_limit, i_tx_byte_limit} = {16'h0002, 16'h0001};
    {i_overrun_fill_char, i_ignored_fill_char} = 16'hc396;
    {i_gpio_data_out, i_gpio_data_out_oe_n} = 2'h2;
    cyc(10);
    i_rst_n = 1'b1;
    cyc(3);
    check("gpio value", 16'h1, 16'(o_pin_data_out));
    check("gpio enable", 16'h0, 16'(o_pin_data_out_oe_n));
    i_enable = 1'b1;
    cyc(3);
    check("owner after enable", 16'(SEM_CPU), 16'(o_sem_owner));
    check("grants after enable", 16'h0, 16'(n_grant));
    check("idle out enable", 16'h1, 16'(o_pin_data_out_oe_n));
    strobe(4'h8);
    cyc(1);
    check("grant on take", 16'h1, 16'(n_grant));
    u_ctrl.begin_frame();
    u_ctrl.xfer(8'h5a, rx);
    check("ignored byte", 16'(i_ignored_fill_char), 16'(rx));
    strobe(4'h4);
    u_ctrl.xfer(8'h5b, rx);
    check("still ignored", 16'(i_ignored_fill_char), 16'(rx));
    u_ctrl.end_frame();
    check("ignored writes", 16'h0, 16'(n_write));
    strobe(4'h4);
    cyc(1);
    check("give when free", 16'(SEM_FREE), 16'(o_sem_owner));
    // Take in the very cycle the select fall is seen: the CPU wins the tie
    fork
      u_ctrl.begin_frame();
      begin
        cyc(2);
        i_take_task = 1'b1;
        cyc(1);
        i_take_task = 1'b0;
      end
    join
    u_ctrl.xfer(8'h44, rx);
    check("race ignored", 16'(i_ignored_fill_char), 16'(rx));
    u_ctrl.end_frame();
    check("race owner", 16'(SEM_CPU), 16'(o_sem_owner));
    // Granted transactions in all four clock modes: two stored, one dropped, two fills
    for (int m = 0; m < 4; m++)
    begin
      i_enable = 1'b0;
      {i_clock_polarity_bit, i_clock_phase_bit} = 2'(m);
      i_short_end_acquire = (m >= 2);
      u_ctrl.idle();
      {ram[8'h40], ram[8'h80], ram[8'h81], ram[8'h82]} = {8'ha0 + 8'(m), 24'h000000};
      cyc(2);
      i_enable = 1'b1;
      cyc(3);
      strobe(4'h4);
      strobe(4'h3);
      cyc(4);
      {n_done, n_full, n_grant} = {32'h0, 32'h0, 32'h0};
      u_ctrl.begin_frame();
      u_ctrl.xfer(8'h11 + 8'(m), rx);
      check("first byte out", 16'(8'ha0 + 8'(m)), 16'(rx));
      if (m == 3) strobe(4'h8);
      if (m == 1) strobe(4'h4);
      check("owner in frame", 16'(SEM_UNIT), 16'(o_sem_owner));
      check("out enabled", 16'h0, 16'(o_pin_data_out_oe_n));
      u_ctrl.xfer(8'h22, rx);
      check("fill byte", 16'(i_overrun_fill_char), 16'(rx));
      u_ctrl.xfer(8'h33, rx);
      check("last fill", 16'(i_overrun_fill_char), 16'(rx));
      u_ctrl.end_frame();
      cyc(40);
      check("first stored", 16'(8'h11 + 8'(m)), 16'(ram[8'h80]));
      check("second stored", 16'h22, 16'(ram[8'h81]));
      check("dropped byte", 16'h0, 16'(ram[8'h82]));
      check("excess flag", 16'h1, 16'(o_rx_excess_flag));
      check("underrun flag", 16'h1, 16'(o_tx_underrun_flag));
      check("rx count", 16'h2, o_rx_bytes_done);
      check("tx count", 16'h1, o_tx_bytes_done);
      check("full events", 16'h1, 16'(n_full));
      check("done events", 16'h1, 16'(n_done));
      check("owner after end", 16'(m >= 2 ? SEM_CPU : SEM_FREE), 16'(o_sem_owner));
      check("grants after end", 16'(m >= 2), 16'(n_grant));
    end
    end_of_test();
  end
endmodule : spi_target_unit_tb_top
